/* core/vdpc_map.vh */
// Register offsets, field positions, reset values for the data path block.
// Assumes inclusion by the design files only.
`ifndef VDPC_MAP_VH
`define VDPC_MAP_VH
`define VDPC_ADDR_DATA_PATH 8'h22
`define VDPC_ADDR_GEN_CTRL 8'h23
`define VDPC_ADDR_IRQ_STATUS 8'h30
`define VDPC_ADDR_IRQ_MASK 8'h31
`define VDPC_RST_DATA_PATH 8'h00
`define VDPC_RST_GEN_CTRL 8'h10
`define VDPC_BIT_HOLD 7
`define VDPC_BIT_PASS_RGB 6
`define VDPC_BIT_DE_POL 5
`define VDPC_BIT_AUD_SUPP 4
`define VDPC_BIT_CHB_OVR 3
`define VDPC_BIT_WIDTH18 2
`define VDPC_BIT_AUD_XPORT 1
`define VDPC_BIT_CHB_EN 0
`define VDPC_BIT_CSUM_EN 7
`define VDPC_GEN_RW_MASK 8'h80
`define VDPC_IRQ_CSUM_ERR 0
`define VDPC_IRQ_REMOTE_LOAD 1
`endif

/* core/vdpc_sync.v */
// Two-flop synchroniser for a single level.
// Assumes the input is asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module vdpc_sync (
    input wire clock,
    input wire rst_n,
    input wire din,
    output wire dout
);
reg stage1;
reg stage2;
always @(posedge clock) begin
    if (!rst_n) begin
        stage1 <= 1'b0;
        stage2 <= 1'b0;
    end else begin
        stage1 <= din;
        stage2 <= stage1;
    end
end
assign dout = stage2;
endmodule // vdpc_sync
`default_nettype wire

/* core/vdpc_top.v */
// Data path control and mode status registers of a video receiver.
// Assumes a same-clock register port, a same-clock remote load strobe,
// a same-clock pixel stream and an asynchronous strap pin.
//
// Summary of operation
// - Hold bit blocks remote register loading
// - Pass-through forwards RGB ignoring data enable
// - Pass-through disables protection, blocks audio
// - Polarity bit inverts data enable sense
// - Suppress bit withholds packetized audio
// - Channel B enable from register or strap
// - Width bit selects 18 or 24 bit
// - Transport bit selects audio carriage method
// - Channel B enable drives its output
// - Checksum enable checks per-line byte, reports
// - Read-only mode status bits exposed
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "vdpc_map.vh"
module vdpc_top (
    input wire clock,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    input wire remote_load,
    input wire [7:0] remote_value,
    input wire strap_chb_pin,
    input wire mode_sel_done,
    input wire low_freq_mode_status,
    input wire repeater_mode,
    input wire backward_mode,
    input wire [23:0] pixel_in,
    input wire de_in,
    input wire line_end,
    input wire [7:0] line_checksum,
    input wire audio_pkt_valid,
    input wire [23:0] audio_pkt_data,
    input wire chb_audio_in,
    output reg [23:0] pixel_out,
    output reg pixel_valid,
    output reg audio_chb_enable,
    output reg audio_channel_b_output,
    output reg content_protect_enable,
    output reg audio_transport_island,
    output reg video_width_18,
    output reg content_protect_status_reg,
    output wire irq
);
////////////////////////////////////////////////////////////////////////////
localparam [7:0] GEN_RST = `VDPC_RST_GEN_CTRL;
localparam [7:0] DP_RST = `VDPC_RST_DATA_PATH;

reg [7:0] data_path_control;
reg [7:0] next_data_path_control;
reg csum_enable;
reg next_csum_enable;
reg [1:0] irq_status;
reg [1:0] next_irq_status;
reg [1:0] irq_mask;
reg [1:0] next_irq_mask;
reg [7:0] line_sum;
reg [7:0] next_line_sum;
reg next_cp_status;
reg [23:0] next_pixel_out;
reg next_pixel_valid;
reg [7:0] general_read;
reg [7:0] next_rdata;
wire strap_chb;
wire de_active;
wire pass_rgb;
wire audio_allowed;
wire wr_dp;
wire wr_gen;
wire wr_irq_status;
wire wr_irq_mask;
wire csum_err;
wire remote_take;
wire chb_sel;
wire [1:0] irq_events;
wire [1:0] irq_clear;
wire [7:0] pixel_sum;

vdpc_sync u_strap (
    .clock(clock),
    .rst_n(rst_n),
    .din(strap_chb_pin),
    .dout(strap_chb)
);

function [7:0] vdpc_add8;
    input [7:0] a;
    input [7:0] b;
    begin
        vdpc_add8 = a + b;
    end
endfunction

function vdpc_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
        vdpc_hit = (addr == target);
    end
endfunction

////////////////////////////////////////////////////////////////////////////
assign wr_dp = reg_write && vdpc_hit(reg_addr, `VDPC_ADDR_DATA_PATH);
assign wr_gen = reg_write && vdpc_hit(reg_addr, `VDPC_ADDR_GEN_CTRL);
assign wr_irq_status = reg_write &&
    vdpc_hit(reg_addr, `VDPC_ADDR_IRQ_STATUS);
assign wr_irq_mask = reg_write &&
    vdpc_hit(reg_addr, `VDPC_ADDR_IRQ_MASK);
assign remote_take = remote_load && !wr_dp &&
    !data_path_control[`VDPC_BIT_HOLD];
assign pass_rgb = data_path_control[`VDPC_BIT_PASS_RGB];
assign audio_allowed = audio_pkt_valid && !pass_rgb &&
    !data_path_control[`VDPC_BIT_AUD_SUPP];
assign de_active = de_in ^ data_path_control[`VDPC_BIT_DE_POL];
assign chb_sel = data_path_control[`VDPC_BIT_CHB_OVR] ?
    data_path_control[`VDPC_BIT_CHB_EN] : strap_chb;
assign pixel_sum = vdpc_add8(vdpc_add8(pixel_in[7:0], pixel_in[15:8]),
    pixel_in[23:16]);

always @* begin
    next_data_path_control = data_path_control;
    if (wr_dp) begin
        next_data_path_control = reg_wdata;
    end else if (remote_take) begin
        next_data_path_control = {data_path_control[`VDPC_BIT_HOLD],
            remote_value[6:0]};
    end
end

always @(posedge clock) begin
    if (!rst_n) begin
        data_path_control <= DP_RST;
    end else begin
        data_path_control <= next_data_path_control;
    end
end

always @* begin
    next_csum_enable = csum_enable;
    if (wr_gen) begin
        next_csum_enable = reg_wdata[`VDPC_BIT_CSUM_EN];
    end
end

always @(posedge clock) begin
    if (!rst_n) begin
        csum_enable <= GEN_RST[`VDPC_BIT_CSUM_EN];
    end else begin
        csum_enable <= next_csum_enable;
    end
end

////////////////////////////////////////////////////////////////////////////
always @* begin
    next_pixel_valid = pass_rgb || de_active;
    if (pass_rgb || de_active) begin
        next_pixel_out = pixel_in;
    end else if (audio_allowed) begin
        next_pixel_out = audio_pkt_data;
    end else begin
        next_pixel_out = 24'h000000;
    end
end

always @(posedge clock) begin
    if (!rst_n) begin
        pixel_out <= 24'h000000;
        pixel_valid <= 1'b0;
    end else begin
        pixel_out <= next_pixel_out;
        pixel_valid <= next_pixel_valid;
    end
end

always @(posedge clock) begin
    if (!rst_n) begin
        audio_chb_enable <= 1'b0;
        audio_channel_b_output <= 1'b0;
        content_protect_enable <= 1'b0;
        audio_transport_island <= 1'b0;
        video_width_18 <= 1'b0;
    end else begin
        audio_chb_enable <= chb_sel;
        audio_channel_b_output <= chb_sel && chb_audio_in;
        content_protect_enable <= !pass_rgb;
        audio_transport_island <= data_path_control[`VDPC_BIT_AUD_XPORT];
        video_width_18 <= data_path_control[`VDPC_BIT_WIDTH18];
    end
end

////////////////////////////////////////////////////////////////////////////
// line checksum compare
assign csum_err = csum_enable && line_end && (line_sum != line_checksum);

always @* begin
    next_line_sum = line_sum;
    if (line_end) begin
        next_line_sum = 8'h00;
    end else if (de_active) begin
        next_line_sum = vdpc_add8(line_sum, pixel_sum);
    end
end

always @* begin
    next_cp_status = content_protect_status_reg;
    if (csum_err) begin
        next_cp_status = 1'b1;
    end else if (line_end) begin
        next_cp_status = 1'b0;
    end
end

always @(posedge clock) begin
    if (!rst_n) begin
        line_sum <= 8'h00;
        content_protect_status_reg <= 1'b0;
    end else begin
        line_sum <= next_line_sum;
        content_protect_status_reg <= next_cp_status;
    end
end

assign irq_events = {remote_take, csum_err};
assign irq_clear = wr_irq_status ? reg_wdata[1:0] : 2'h0;

// Sticky events, set wins over clear
always @* begin
    next_irq_status = (irq_status & ~irq_clear) | irq_events;
    next_irq_mask = irq_mask;
    if (wr_irq_mask) begin
        next_irq_mask = reg_wdata[1:0];
    end
end

always @(posedge clock) begin
    if (!rst_n) begin
        irq_status <= 2'h0;
        irq_mask <= 2'h0;
    end else begin
        irq_status <= next_irq_status;
        irq_mask <= next_irq_mask;
    end
end

assign irq = |(irq_status & irq_mask);

////////////////////////////////////////////////////////////////////////////
always @* begin
    general_read = {csum_enable, 2'h0, mode_sel_done,
        low_freq_mode_status, repeater_mode, backward_mode, chb_sel};
end

always @* begin
    next_rdata = 8'h00;
    if (reg_read) begin
        case (reg_addr)
            `VDPC_ADDR_DATA_PATH: begin
                next_rdata = data_path_control;
            end
            `VDPC_ADDR_GEN_CTRL: begin
                next_rdata = general_read;
            end
            `VDPC_ADDR_IRQ_STATUS: begin
                next_rdata = {6'h00, irq_status};
            end
            `VDPC_ADDR_IRQ_MASK: begin
                next_rdata = {6'h00, irq_mask};
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end
end

always @(posedge clock) begin
    if (!rst_n) begin
        reg_rdata <= 8'h00;
    end else begin
        reg_rdata <= next_rdata;
    end
end
endmodule // vdpc_top
`default_nettype wire

/* tb/vdpc_top_props.sv */
// Checker for the data path control block.
// Assumes the ports of vdpc_top on one clock.
`timescale 1ns/1ps
`default_nettype none
module vdpc_top_props (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic line_end,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic chb_audio_in,
    input wire logic pixel_valid,
    input wire logic audio_chb_enable,
    input wire logic irq,
    input wire logic audio_channel_b_output,
    input wire logic content_protect_enable,
    input wire logic video_width_18,
    input wire logic content_protect_status_reg
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire wr22 = reg_write && reg_addr == 8'h22;
    width_sel_a: assert property (
        wr22 |=> ##1 video_width_18 == $past(reg_wdata[2], 2))
        else $error("width select wrong");
    prot_off_a: assert property (
        wr22 |=> ##1 content_protect_enable == !$past(reg_wdata[6], 2))
        else $error("protection enable wrong");
    pass_valid_a: assert property (
        !content_protect_enable && $past(rst_n, 2) |-> pixel_valid)
        else $error("pass-through not valid");
    rd_idle_a: assert property (
        !reg_read |=> reg_rdata == 8'h00) else $error("read data not idle");
    rsvd_zero_a: assert property (
        reg_read && reg_addr == 8'h23 |=> reg_rdata[6:5] == 2'b00)
        else $error("reserved bits set");
    chb_gate_a: assert property (
        audio_channel_b_output == (audio_chb_enable && $past(chb_audio_in)))
        else $error("channel B gating wrong");
    irq_mask_a: assert property (
        reg_write && reg_addr == 8'h31 && reg_wdata == 8'h00 |=> !irq)
        else $error("masked interrupt seen");
    csum_flag_a: assert property (
        $rose(content_protect_status_reg) |-> $past(line_end))
        else $error("checksum flag without line end");
    cover property (wr22 ##2 video_width_18);
    cover property ($rose(content_protect_status_reg));
    cover property ($rose(irq));
endmodule // vdpc_top_props
bind vdpc_top vdpc_top_props u_props (.clock, .rst_n, .reg_write,
    .reg_read, .line_end, .reg_addr, .reg_wdata, .reg_rdata, .chb_audio_in,
    .pixel_valid, .audio_chb_enable, .irq, .audio_channel_b_output,
    .content_protect_enable, .video_width_18, .content_protect_status_reg);
`default_nettype wire

/* tb/vdpc_fwd_model.sv */
// Remote serializer model issuing forward channel loads.
// Assumes requests from the bench on the same clock.
`timescale 1ns/1ps
`default_nettype none
module vdpc_fwd_model (
    input wire logic clock,
    input wire logic req,
    input wire logic [7:0] val,
    output var logic remote_load = 1'b0,
    output var logic [7:0] remote_value = 8'h00
);
    // Idle value line shows the inverse
    always @(posedge clock) begin
        remote_load <= req;
        remote_value <= req ? val : ~remote_value;
    end
endmodule // vdpc_fwd_model
`default_nettype wire

/* tb/video_data_path_control_tb_top.sv */
// Bench for the data path control block.
// Assumes vdpc_top and the forward channel model.
`timescale 1ns/1ps
`default_nettype none
module video_data_path_control_tb_top;
    logic clock = 0, rst_n = 0, reg_write = 0, reg_read = 0, req = 0;
    logic de_in = 0, line_end = 0, chb_audio_in = 1, repeater_mode = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, val = 0, line_checksum = 0;
    logic [7:0] reg_rdata, remote_value;
    logic remote_load, pixel_valid, audio_chb_enable, chb_o, cp_en, isl;
    logic w18, cs, irq;
    logic [23:0] pixel_out, pixel_in = 24'hABCDEF;
    logic strap_chb_pin = 0, audio_pkt_valid = 0;
    logic [23:0] audio_pkt_data = 24'h000000;
    int checks = 0, num_errors = 0;
    vdpc_top i_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .remote_load, .remote_value, .repeater_mode,
        .strap_chb_pin, .mode_sel_done(1'b1), .pixel_in, .de_in,
        .low_freq_mode_status(1'b0), .backward_mode(1'b0), .line_end,
        .line_checksum, .audio_pkt_valid, .audio_pkt_data,
        .chb_audio_in, .pixel_out, .pixel_valid, .audio_chb_enable, .irq,
        .audio_channel_b_output(chb_o), .content_protect_enable(cp_en),
        .audio_transport_island(isl), .video_width_18(w18),
        .content_protect_status_reg(cs));
    vdpc_fwd_model i_fwd (.clock, .req, .val, .remote_load, .remote_value);
    initial forever #2 clock = ~clock;
    task chk(input string n, input logic [23:0] s, e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task w;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge clock);
        reg_write <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 0;
    endtask
    task rd(input logic [7:0] a, e);
        @(posedge clock);
        reg_read <= 1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 0;
        #1 chk("rdata", reg_rdata, e);
    endtask
    task rl(input logic [7:0] v);
        @(posedge clock);
        req <= 1;
        val <= v;
        @(posedge clock);
        req <= 0;
        w;
    endtask
    task line(input logic [7:0] c);
        @(posedge clock);
        de_in <= 1;
        @(posedge clock);
        de_in <= 0;
        line_end <= 1;
        line_checksum <= c;
        @(posedge clock);
        line_end <= 0;
        w;
    endtask
    task t_regs;
        rd(8'h22, 8'h00);
        rd(8'h23, 8'h10);
        wr(8'h23, 8'hFF);
        repeater_mode <= 1;
        rd(8'h23, 8'h94);
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h00);
    endtask
    task t_remote;
        wr(8'h31, 8'h02);
        rl(8'h04);
        chk("width18", w18, 1);
        chk("irq", irq, 1);
        wr(8'h22, 8'h80);
        wr(8'h30, 8'h02);
        rl(8'h7F);
        rd(8'h22, 8'h80);
        chk("irq", irq, 0);
    endtask
    task t_pass;
        wr(8'h22, 8'hC2);
        w;
        chk("valid", pixel_valid, 1);
        chk("protect", cp_en, 0);
        chk("island", isl, 1);
        wr(8'h22, 8'hA0);
        w;
        chk("pixel", pixel_out, 24'hABCDEF);
        chk("valid", pixel_valid, 1);
    endtask
    task t_audio;
        wr(8'h22, 8'h80);
        audio_pkt_valid <= 1;
        audio_pkt_data <= 24'h123456;
        w;
        chk("valid", pixel_valid, 0);
        chk("audio", pixel_out, 24'h123456);
        wr(8'h22, 8'h90);
        w;
        chk("audio", pixel_out, 24'h000000);
        wr(8'h22, 8'hC0);
        w;
        chk("pixel", pixel_out, 24'hABCDEF);
        @(posedge clock);
        audio_pkt_valid <= 0;
    endtask
    task t_chb;
        wr(8'h22, 8'h89);
        w;
        chk("chb en", audio_chb_enable, 1);
        chk("chb out", chb_o, 1);
        wr(8'h22, 8'h88);
        w;
        chk("chb out", chb_o, 0);
        wr(8'h22, 8'h80);
        strap_chb_pin <= 1;
        w;
        chk("chb en", audio_chb_enable, 1);
        rd(8'h23, 8'h95);
        @(posedge clock);
        strap_chb_pin <= 0;
        w;
        chk("chb en", audio_chb_enable, 0);
    endtask
    task t_csum;
        wr(8'h22, 8'h80);
        wr(8'h31, 8'h01);
        line(8'h00);
        line(8'h67);
        chk("csum", cs, 0);
        wr(8'h30, 8'h01);
        #1 chk("irq", irq, 0);
        line(8'h00);
        chk("csum", cs, 1);
        chk("irq", irq, 1);
        wr(8'h31, 8'h00);
        #1 chk("irq", irq, 0);
    endtask
    task t_reset;
        wr(8'h22, 8'h45);
        rst_n <= 0;
        repeat (3) @(posedge clock);
        rst_n <= 1;
        rd(8'h22, 8'h00);
        rd(8'h23, 8'h14);
        chk("csum", cs, 0);
        chk("irq", irq, 0);
    endtask
    task test_done;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #40000;
        num_errors++;
        test_done;
    end
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1;
        t_regs;
        t_remote;
        t_pass;
        t_audio;
        t_chb;
        t_csum;
        t_reset;
        test_done;
    end
endmodule // video_data_path_control_tb_top
`default_nettype wire
